// >>> inc/sbt_pkg.sv
// Package holding constants for the boundary-scan test access port
package sbt_pkg;

  // ----------------------------------------
  // Instruction codes
  // ----------------------------------------
  localparam int IR_WIDTH = 3;
  localparam logic [2:0] OP_EXT_TEST = 3'h0;
  localparam logic [2:0] OP_IDENT = 3'h1;
  localparam logic [2:0] OP_HIZ_SAMPLE = 3'h2;
  localparam logic [2:0] OP_RSVD_A = 3'h3;
  localparam logic [2:0] OP_SAMPLE_PRELOAD = 3'h4;
  localparam logic [2:0] OP_RSVD_B = 3'h5;
  localparam logic [2:0] OP_RSVD_C = 3'h6;
  localparam logic [2:0] OP_BYPASS = 3'h7;
  // Value captured into the instruction shifter (low bits 01)
  localparam logic [2:0] IR_CAPTURE = 3'h1;

  // ----------------------------------------
  // Identification register layout
  // ----------------------------------------
  localparam int ID_WIDTH = 32;
  localparam int ID_REV_MSB = 31;
  localparam int ID_REV_LSB = 29;
  localparam int ID_DEPTH_MSB = 28;
  localparam int ID_DEPTH_LSB = 24;
  localparam int ID_ARCH_MSB = 23;
  localparam int ID_ARCH_LSB = 18;
  localparam int ID_DEV_MSB = 17;
  localparam int ID_DEV_LSB = 12;
  localparam int ID_VENDOR_MSB = 11;
  localparam int ID_VENDOR_LSB = 1;
  localparam int ID_PRESENT_BIT = 0;
  localparam logic ID_PRESENT = 1'h1;

  // ----------------------------------------
  // Boundary chain lengths and presets
  // ----------------------------------------
  localparam int CHAIN_LEN_119 = 85;
  localparam int CHAIN_LEN_165 = 89;
  localparam logic PRESET_INTERNAL = 1'h1;
  localparam logic PRESET_NC = 1'h0;
  localparam logic BYPASS_CAPTURE = 1'h0;

endpackage

// >>> logic/sbt_sync.sv
// Two flip-flop synchroniser for a level
`timescale 1ns/1ns
module sbt_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule

// >>> logic/sbt_tap_fsm.sv
// Sixteen-state test access port controller
`timescale 1ns/1ns
module sbt_tap_fsm (
  input wire logic tck_i,
  input wire logic trst_i,
  input wire logic tms_i,
  output logic tlr_o,
  output logic cap_dr_o,
  output logic sh_dr_o,
  output logic upd_dr_o,
  output logic cap_ir_o,
  output logic sh_ir_o,
  output logic upd_ir_o
);

  typedef enum logic [3:0] {
    S_TLR, S_RTI, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR, S_EX2_DR,
    S_UPD_DR, S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PA_IR, S_EX2_IR, S_UPD_IR
  } sbt_tap_type;

  sbt_tap_type state;
  sbt_tap_type next_state;

  // Standard state transitions steered by the mode select
  always_comb begin
    next_state = state;
    unique case (state)
      S_TLR: next_state = tms_i ? S_TLR : S_RTI;
      S_RTI: next_state = tms_i ? S_SEL_DR : S_RTI;
      S_SEL_DR: next_state = tms_i ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: next_state = tms_i ? S_EX1_DR : S_SH_DR;
      S_SH_DR: next_state = tms_i ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: next_state = tms_i ? S_UPD_DR : S_PA_DR;
      S_PA_DR: next_state = tms_i ? S_EX2_DR : S_PA_DR;
      S_EX2_DR: next_state = tms_i ? S_UPD_DR : S_SH_DR;
      S_UPD_DR: next_state = tms_i ? S_SEL_DR : S_RTI;
      S_SEL_IR: next_state = tms_i ? S_TLR : S_CAP_IR;
      S_CAP_IR: next_state = tms_i ? S_EX1_IR : S_SH_IR;
      S_SH_IR: next_state = tms_i ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: next_state = tms_i ? S_UPD_IR : S_PA_IR;
      S_PA_IR: next_state = tms_i ? S_EX2_IR : S_PA_IR;
      S_EX2_IR: next_state = tms_i ? S_UPD_IR : S_SH_IR;
      S_UPD_IR: next_state = tms_i ? S_SEL_DR : S_RTI;
    endcase
  end

  // State register, reset to Test-Logic-Reset
  always_ff @(posedge tck_i) begin
    if (trst_i) begin
      state <= S_TLR;
    end else begin
      state <= next_state;
    end
  end

  // State decodes
  assign tlr_o = (state == S_TLR);
  assign cap_dr_o = (state == S_CAP_DR);
  assign sh_dr_o = (state == S_SH_DR);
  assign upd_dr_o = (state == S_UPD_DR);
  assign cap_ir_o = (state == S_CAP_IR);
  assign sh_ir_o = (state == S_SH_IR);
  assign upd_ir_o = (state == S_UPD_IR);

endmodule

// >>> logic/sbt_tap.sv
// Boundary-scan test access port of a pipelined SRAM
`timescale 1ns/1ns

// Overview of operation
// - Ext-test: capture ring, chain routed, ring driven, outputs set by control cell
// - Ident: load ID, route it, memory untouched
// - Hiz-sample: capture ring, chain routed, outputs off
// - Sample/preload: capture ring, chain routed, untouched
// - Bypass: one-bit register routed, memory untouched
// - ID fields: rev, depth, arch, dev, vendor
// - ID bit zero always reads one
// - Chain is 85 or 89 cells long
// - 119-ball: cell 85 internal, preset high
// - Unconnected-ball cells preset low
// - Three-bit instruction, effective at Update-IR
// - Instruction resets to ident on reset
// - Latched control cell gates outputs under ext-test
// - 165-ball: cell 89 internal, preset high
module sbt_tap #(
  parameter bit PKG_165 = 1'b0,
  parameter logic [2:0] ID_REV = 3'h0,
  parameter logic [4:0] ID_DEPTH = 5'h0,   // Arbitrary value
  parameter logic [5:0] ID_ARCH = 6'h0,    // Arbitrary value
  parameter logic [5:0] ID_DEV = 6'h0,     // Arbitrary value
  parameter logic [10:0] ID_VENDOR = 11'h0, // Arbitrary value
  parameter int CHAIN_LEN = PKG_165 ? sbt_pkg::CHAIN_LEN_165 : sbt_pkg::CHAIN_LEN_119,
  parameter logic [CHAIN_LEN-2:0] NC_MASK = '0
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  input wire logic [CHAIN_LEN-2:0] ring_i,
  output logic [CHAIN_LEN-2:0] ring_o,
  output logic ring_drive_o,
  output logic mem_out_en_o
);

  // ----------------------------------------
  // Reset into the test clock domain
  // ----------------------------------------
  logic trst;

  sbt_sync #(.WIDTH(1)) u_rst_sync (
    .clk_i(tck_i),
    .srst_i(1'b0),
    .async_i(srst_i),
    .sync_o(trst)
  );

  // Ring inputs pass two flops on the test clock before capture
  logic [CHAIN_LEN-2:0] ring_sync;

  sbt_sync #(.WIDTH(CHAIN_LEN-1)) u_ring_sync (
    .clk_i(tck_i),
    .srst_i(trst),
    .async_i(ring_i),
    .sync_o(ring_sync)
  );

  // ----------------------------------------
  // Controller
  // ----------------------------------------
  logic tlr;
  logic cap_dr;
  logic sh_dr;
  logic upd_dr;
  logic cap_ir;
  logic sh_ir;
  logic upd_ir;

  sbt_tap_fsm u_fsm (
    .tck_i(tck_i),
    .trst_i(trst),
    .tms_i(tms_i),
    .tlr_o(tlr),
    .cap_dr_o(cap_dr),
    .sh_dr_o(sh_dr),
    .upd_dr_o(upd_dr),
    .cap_ir_o(cap_ir),
    .sh_ir_o(sh_ir),
    .upd_ir_o(upd_ir)
  );

  // ----------------------------------------
  // Instruction register
  // ----------------------------------------
  logic [2:0] ir_shift;
  logic [2:0] instruction_register;

  // Shift stage of the instruction register
  always_ff @(posedge tck_i) begin
    if (trst_i_or_tlr()) begin
      ir_shift <= sbt_pkg::IR_CAPTURE;
    end else if (cap_ir) begin
      ir_shift <= sbt_pkg::IR_CAPTURE;
    end else if (sh_ir) begin
      ir_shift <= {tdi_i, ir_shift[2:1]};
    end
  end

  // Current instruction changes at Update-IR, and returns to ident on reset or in Test-Logic-Reset
  always_ff @(posedge tck_i) begin
    if (trst_i_or_tlr()) begin
      instruction_register <= sbt_pkg::OP_IDENT;
    end else if (upd_ir) begin
      instruction_register <= ir_shift;
    end
  end

  function automatic logic trst_i_or_tlr();
    return trst | tlr;
  endfunction

  // Instruction decode; reserved codes fall to bypass path
  logic sel_chain;
  logic sel_id;
  logic hiz_force;
  logic ext_test;

  always_comb begin
    sel_chain = 1'b0;
    sel_id = 1'b0;
    hiz_force = 1'b0;
    ext_test = 1'b0;
    unique case (instruction_register)
      sbt_pkg::OP_EXT_TEST: begin
        sel_chain = 1'b1;
        ext_test = 1'b1;
      end
      sbt_pkg::OP_IDENT: sel_id = 1'b1;
      sbt_pkg::OP_HIZ_SAMPLE: begin
        sel_chain = 1'b1;
        hiz_force = 1'b1;
      end
      sbt_pkg::OP_SAMPLE_PRELOAD: sel_chain = 1'b1;
      sbt_pkg::OP_BYPASS: sel_chain = 1'b0;
      default: sel_chain = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Bypass register
  // ----------------------------------------
  logic bypass_register;

  // Captures zero, then a one-clock delay of the serial input
  always_ff @(posedge tck_i) begin
    if (trst) begin
      bypass_register <= sbt_pkg::BYPASS_CAPTURE;
    end else if (cap_dr) begin
      bypass_register <= sbt_pkg::BYPASS_CAPTURE;
    end else if (sh_dr) begin
      bypass_register <= tdi_i;
    end
  end

  // ----------------------------------------
  // Identification register
  // ----------------------------------------
  logic [31:0] id_value;
  logic [31:0] identification_register;

  // Field assembly with the presence flag forced high
  always_comb begin
    id_value = '0;
    id_value[sbt_pkg::ID_REV_MSB:sbt_pkg::ID_REV_LSB] = ID_REV;
    id_value[sbt_pkg::ID_DEPTH_MSB:sbt_pkg::ID_DEPTH_LSB] = ID_DEPTH;
    id_value[sbt_pkg::ID_ARCH_MSB:sbt_pkg::ID_ARCH_LSB] = ID_ARCH;
    id_value[sbt_pkg::ID_DEV_MSB:sbt_pkg::ID_DEV_LSB] = ID_DEV;
    id_value[sbt_pkg::ID_VENDOR_MSB:sbt_pkg::ID_VENDOR_LSB] = ID_VENDOR;
    id_value[sbt_pkg::ID_PRESENT_BIT] = sbt_pkg::ID_PRESENT;
  end

  // Loaded at Capture-DR, shifted toward the serial output
  always_ff @(posedge tck_i) begin
    if (trst) begin
      identification_register <= id_value;
    end else if (cap_dr && sel_id) begin
      identification_register <= id_value;
    end else if (sh_dr && sel_id) begin
      identification_register <= {tdi_i, identification_register[31:1]};
    end
  end

  // ----------------------------------------
  // Boundary chain: top cell is the output-control cell
  // ----------------------------------------
  logic [CHAIN_LEN-1:0] chain_shift;
  logic [CHAIN_LEN-1:0] chain_latch;
  logic [CHAIN_LEN-1:0] chain_preset;

  // Internal cell high, unconnected ball cells low, the rest low too
  assign chain_preset = {sbt_pkg::PRESET_INTERNAL,
                         NC_MASK & {(CHAIN_LEN-1){sbt_pkg::PRESET_NC}}};

  // Capture of the ring, shift with the most significant bit at input
  always_ff @(posedge tck_i) begin
    if (trst) begin
      chain_shift <= chain_preset;
    end else if (cap_dr && sel_chain) begin
      chain_shift <= {chain_shift[CHAIN_LEN-1], ring_sync};
    end else if (sh_dr && sel_chain) begin
      chain_shift <= {tdi_i, chain_shift[CHAIN_LEN-1:1]};
    end
  end

  // Preload latch, updated at Update-DR, preset on reset
  always_ff @(posedge tck_i) begin
    if (trst_i_or_tlr()) begin
      chain_latch <= chain_preset;
    end else if (upd_dr && sel_chain) begin
      chain_latch <= chain_shift;
    end
  end

  // ----------------------------------------
  // Serial output, changes on the falling test clock
  // ----------------------------------------
  logic next_tdo;
  logic tdo_en;

  always_comb begin
    if (sh_ir) begin
      next_tdo = ir_shift[0];
    end else if (sel_id) begin
      next_tdo = identification_register[0];
    end else if (sel_chain) begin
      next_tdo = chain_shift[0];
    end else begin
      next_tdo = bypass_register;
    end
  end

  always_ff @(negedge tck_i) begin
    if (trst) begin
      tdo_o <= 1'b0;
      tdo_en <= 1'b0;
    end else begin
      tdo_o <= next_tdo;
      tdo_en <= sh_ir | sh_dr;
    end
  end

  assign tdo_oe_o = tdo_en;

  // ----------------------------------------
  // Memory-side controls, moved into the memory clock domain
  // ----------------------------------------
  logic out_en_tck;
  logic drive_tck;
  logic [CHAIN_LEN-2:0] drive_data;

  // Output enable per instruction and latched control cell, taken on the
  // falling test clock so a clock that stops after Update-IR still delivers it
  always_ff @(negedge tck_i) begin
    if (trst) begin
      out_en_tck <= 1'b1;
      drive_tck <= 1'b0;
    end else begin
      out_en_tck <= !(hiz_force || (ext_test && !chain_latch[CHAIN_LEN-1]));
      drive_tck <= ext_test;
    end
  end

  assign drive_data = chain_latch[CHAIN_LEN-2:0];

  // Flips at every Update-DR of the chain, telling the memory side the latch moved
  logic upd_toggle;

  always_ff @(posedge tck_i) begin
    if (trst) begin
      upd_toggle <= 1'b0;
    end else if (upd_dr && sel_chain) begin
      upd_toggle <= !upd_toggle;
    end
  end

  logic [2:0] ctl_sync;

  sbt_sync #(.WIDTH(3)) u_ctl_sync (
    .clk_i(mclk_i),
    .srst_i(srst_i),
    .async_i({upd_toggle, out_en_tck, drive_tck}),
    .sync_o(ctl_sync)
  );

  // Last toggle level seen on the memory clock
  logic upd_seen;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      upd_seen <= 1'b0;
    end else begin
      upd_seen <= ctl_sync[2];
    end
  end

  // Latch word taken only while it is settled: as the drive turns on, or
  // once the toggle of a new Update-DR has crossed, never mid-update
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ring_o <= '0;
      ring_drive_o <= 1'b0;
      mem_out_en_o <= 1'b1;
    end else begin
      if (ctl_sync[0] && (!ring_drive_o || (ctl_sync[2] != upd_seen))) begin
        ring_o <= drive_data;
      end
      ring_drive_o <= ctl_sync[0];
      mem_out_en_o <= ctl_sync[1];
    end
  end

endmodule

// >>> test/sbt_tap_monitor.sv
// Checker of the scan port, bound to its top module
`timescale 1ns/1ns
module sbt_tap_monitor #(
  parameter int CHAIN_LEN = 85
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_o,
  input wire logic [CHAIN_LEN-2:0] ring_i,
  input wire logic [CHAIN_LEN-2:0] ring_o,
  input wire logic ring_drive_o,
  input wire logic mem_out_en_o
);
  logic tck_q;
  logic [3:0] since_tck;
  logic [2:0] ones;
  logic tlr_exit;
  // Counts memory clocks since the last test clock rise
  always_ff @(posedge mclk_i) begin
    tck_q <= tck_i;
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i || (tck_i && !tck_q)) begin
      since_tck <= 4'h0;
    end else if (since_tck != 4'hf) begin
      since_tck <= since_tck + 4'h1;
    end
  end
  // Marks the step out of Test-Logic-Reset after five high mode bits
  always_ff @(posedge tck_i) begin
    if (srst_i || !tms_i) begin
      ones <= 3'h0;
    end else if (ones != 3'h7) begin
      ones <= ones + 3'h1;
    end
  end
  always_ff @(posedge tck_i) begin
    tlr_exit <= !srst_i && !tms_i && (ones >= 3'h5);
  end

  a_outen_cause: assert property (@(posedge mclk_i) disable iff (srst_i)
    $changed(mem_out_en_o) |-> since_tck <= 4'h6) else $error("out enable moved alone");
  a_drive_cause: assert property (@(posedge mclk_i) disable iff (srst_i)
    $changed(ring_drive_o) |-> since_tck <= 4'h6) else $error("ring drive moved alone");
  a_ring_cause: assert property (@(posedge mclk_i) disable iff (srst_i)
    $changed(ring_o) |-> since_tck <= 4'h6) else $error("ring output moved alone");
  a_tlr_outen: assert property (@(posedge mclk_i) disable iff (srst_i)
    $rose(tlr_exit) |-> ##[1:12] mem_out_en_o) else $error("outputs off after reset");
  a_tlr_nodrive: assert property (@(posedge mclk_i) disable iff (srst_i)
    $rose(tlr_exit) |-> ##[1:12] !ring_drive_o) else $error("ring driven after reset");
  a_tdo_on_fall: assert property (@(posedge mclk_i) disable iff (srst_i)
    $changed(tdo_o) |-> !tck_i) else $error("serial out moved on rise");
  a_oe_shift_in: assert property (@(negedge tck_i) disable iff (srst_i)
    $rose(tdo_oe_o) |-> !$past(tms_i)) else $error("out enable rose badly");
  a_oe_shift_out: assert property (@(negedge tck_i) disable iff (srst_i)
    $fell(tdo_oe_o) |-> $past(tms_i)) else $error("out enable fell badly");

  c_low_cell: cover property (@(posedge mclk_i) ring_drive_o && !mem_out_en_o);
  c_tlr_exit: cover property (@(posedge mclk_i) $rose(tlr_exit));
  c_shift: cover property (@(negedge tck_i) $rose(tdo_oe_o));
endmodule

bind sbt_tap sbt_tap_monitor #(.CHAIN_LEN(CHAIN_LEN)) i_sbt_tap_monitor (
  .mclk_i(mclk_i), .srst_i(srst_i), .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i),
  .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .ring_i(ring_i), .ring_o(ring_o),
  .ring_drive_o(ring_drive_o), .mem_out_en_o(mem_out_en_o));

// >>> test/sbt_jtag_model.sv
// Behavioural test controller driving the scan port
`timescale 1ns/1ns
module sbt_jtag_model (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  // Clock stands low between frames
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // One clock: inputs change while low, serial out taken at the rise
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #16;
    tdo = tdo_i;
    tck_o = 1'b1;
    #16;
    tck_o = 1'b0;
  endtask
  // Idle to idle through one scan; callers give reserved codes only as refusals
  task automatic scan(input logic is_ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic d;
    dout = '0;
    tick(1'b1, 1'b0, d);
    if (is_ir) begin
      tick(1'b1, 1'b0, d);
    end
    tick(1'b0, 1'b0, d);
    tick(1'b0, 1'b0, d);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], dout[i]);
    end
    tick(1'b1, 1'b0, d);
    tick(1'b0, 1'b0, d);
  endtask
endmodule

// >>> test/tb.sv
// Self-checking bench for the scan port
`timescale 1ns/1ns
module tb;
  localparam int CL = sbt_pkg::CHAIN_LEN_119;
  localparam logic [2:0] REV = 3'h5; // Arbitrary value
  localparam logic [4:0] DEP = 5'h0a; // Arbitrary value
  localparam logic [5:0] ARC = 6'h2c; // Arbitrary value
  localparam logic [5:0] DEV = 6'h13; // Arbitrary value
  localparam logic [10:0] VEN = 11'h2a5; // Arbitrary value
  localparam logic [31:0] ID_EXP = {REV, DEP, ARC, DEV, VEN, sbt_pkg::ID_PRESENT};
  localparam logic [CL-2:0] PRE = {21{4'h6}};
  logic [2:0] codes [4] = '{sbt_pkg::OP_BYPASS, sbt_pkg::OP_RSVD_A, sbt_pkg::OP_RSVD_B,
                            sbt_pkg::OP_RSVD_C};
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe, ring_drive, mem_out_en, bit1;
  logic [CL-2:0] ring_i = {21{4'h9}};
  logic [CL-2:0] ring_o;
  logic [127:0] dout;
  localparam int CL2 = sbt_pkg::CHAIN_LEN_165;
  logic tdo2, tdo_oe2;
  logic [CL2-2:0] ring2_i = {22{4'h3}};
  logic [127:0] dout2 = '0;
  int fails = 0;
  int samples_checked = 0;

  // Memory clock
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end

  sbt_tap #(.PKG_165(1'b0), .ID_REV(REV), .ID_DEPTH(DEP), .ID_ARCH(ARC), .ID_DEV(DEV),
    .ID_VENDOR(VEN)) i_sbt_tap (.mclk_i(mclk_i), .srst_i(srst_i), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .ring_i(ring_i), .ring_o(ring_o),
    .ring_drive_o(ring_drive), .mem_out_en_o(mem_out_en));
  sbt_jtag_model i_sbt_jtag_model (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
  // Larger package variant on the same scan stream, serial out collected below
  sbt_tap #(.PKG_165(1'b1)) i_sbt_tap_165 (.mclk_i(mclk_i), .srst_i(srst_i), .tck_i(tck),
    .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo2), .tdo_oe_o(tdo_oe2), .ring_i(ring2_i), .ring_o(),
    .ring_drive_o(), .mem_out_en_o());

  // Bits shifted out by the larger variant, newest on top
  always @(posedge tck) begin
    if (tdo_oe2) begin
      dout2 <= {tdo2, dout2[127:1]};
    end
  end

  // Comparison, verdict and helpers
  task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic done(input string t);
    $display("Test %s over, mismatches so far %0d", t, fails);
  endtask
  // Lets the level cross into the memory domain, then shifts the test clock phase
  task automatic settle();
    repeat (5) @(negedge mclk_i);
    #3;
  endtask
  task automatic scan(input int n, input logic [127:0] din);
    i_sbt_jtag_model.scan(1'b0, n, din, dout);
    settle();
  endtask
  task automatic ir(input logic [2:0] code);
    i_sbt_jtag_model.scan(1'b1, 3, {125'h0, code}, dout);
    check(dout[2:0], sbt_pkg::IR_CAPTURE, "ir capture");
    settle();
  endtask
  task automatic tlr();
    repeat (5) i_sbt_jtag_model.tick(1'b1, 1'b0, bit1);
    i_sbt_jtag_model.tick(1'b0, 1'b0, bit1);
    settle();
  endtask

  // Hang guard
  initial begin
    #400000;
    fails++;
    $display("[ERR] %0t run too long", $time);
    wrap_up();
  end

  // Main sequence
  initial begin
    #3;
    fork
      repeat (16) @(negedge mclk_i);
      repeat (3) i_sbt_jtag_model.tick(1'b1, 1'b0, bit1);
    join
    srst_i = 1'b0;
    #3;
    tlr();
    scan(32, '0);
    check(dout[31:0], ID_EXP, "ident fields");
    check(dout[0], 1'b1, "ident bit0");
    check(mem_out_en, 1'b1, "ident outputs");
    done("ident");
    foreach (codes[k]) begin
      ir(codes[k]);
      scan(4, 128'hb);
      check(dout[3:0], 4'h6, "bypass path");
      check({ring_drive, mem_out_en}, 2'h1, "bypass outputs");
    end
    done("bypass");
    ir(sbt_pkg::OP_SAMPLE_PRELOAD);
    scan(CL + 4, {39'h0, 1'b0, PRE, 4'ha});
    check(dout[CL+3:0], {4'ha, 1'b1, ring_i}, "sample chain");
    check(dout[CL-1], 1'b1, "control preset");
    check(dout2[127:128-CL2], {1'b1, ring2_i}, "chain of 89");
    check(dout2[127], 1'b1, "control preset 89");
    check({ring_drive, mem_out_en}, 2'h1, "sample outputs");
    done("sample");
    ir(sbt_pkg::OP_EXT_TEST);
    check({ring_drive, mem_out_en}, 2'h2, "extest low cell");
    check(ring_o, PRE, "preload driven");
    scan(CL, {43'h0, 1'b1, PRE});
    check(dout[CL-1:0], {1'b0, ring_i}, "extest capture");
    check(mem_out_en, 1'b1, "extest high cell");
    done("extest");
    ring_i = {21{4'hc}};
    ir(sbt_pkg::OP_HIZ_SAMPLE);
    check({ring_drive, mem_out_en}, 2'h0, "hiz outputs");
    scan(CL, {43'h0, 1'b1, PRE});
    check(dout[CL-1:0], {1'b1, ring_i}, "hiz capture");
    done("hiz");
    tlr();
    check({ring_drive, mem_out_en}, 2'h1, "reset outputs");
    scan(32, '0);
    check(dout[31:0], ID_EXP, "ident after reset");
    done("tlr");
    wrap_up();
  end
endmodule
